// ==== src/qbg_params.svh ====
// Summary of operation
// - Three independent eight-pin port groups, one latch bit per pin.
// - Reset leaves general purpose mode pins as inputs; pin_mode comes from outside and is not reset.
// - Each of the 24 pins takes its own function select, independently.
// - Drive mode follows function: quasi, open drain, analog, push-pull, input only.
// - Latches are bit addressable: single-bit set, clear or test.
// - Latch 0 in general purpose mode: low side on, high side and pull-ups off.
// - Writing 1 releases low side, pulses high side one clock, pull-ups stay on.
// - High-side pulse only on a latch 0-to-1 change, never on rewrite.
// - Reset loads all three latches with all ones.
// - Strong pull-up stays on while pin is high, drops when pulled low.
// - Read-modify-write port reads return the latch, not the pin.
// - All other port reads return the sampled pin level.
// - Dedicated external bus ports carry only core bus signals, never GPIO.
// - Second port latch sits at address B0h, resets to all ones.
// - Third port latch sits at address C0h, resets to all ones.
`ifndef QBG_PARAMS_SVH
`define QBG_PARAMS_SVH
`define QBG_NUM_PORTS 3
`define QBG_PORT_W 8
`define QBG_BIT_IDX_W 3
`define QBG_ADDR_PORT_ONE 8'h90
`define QBG_ADDR_PORT_TWO 8'hb0
`define QBG_ADDR_PORT_THREE 8'hc0
`define QBG_BIT_BASE_LOW 3'h0
`define QBG_LATCH_RESET 8'hff
`define QBG_UNMAPPED_RD 8'h00
`define QBG_SYNC_RESET 1'b1
`define QBG_BUS_ADDR_IDLE 4'hf
`define QBG_BUS_AD_IDLE 8'hff
`endif

// ==== src/qbg_pkg.sv ====
package qbg_pkg;
  // Per-pin function, supplied by the function-select logic
  typedef enum logic [2:0] {
    QBG_GPIO,
    QBG_QUASI_ALT,
    QBG_OPEN_DRAIN,
    QBG_ANALOG,
    QBG_PUSH_PULL,
    QBG_INPUT_ONLY
  } qbg_mode_t;
endpackage

// ==== src/qbg_pin_sync.sv ====
`timescale 1ns/1ps
`include "qbg_params.svh"
module qbg_pin_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_level
);
  import qbg_pkg::*;
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } qbg_sync_t;
  qbg_sync_t st_reg;
  qbg_sync_t st_next;

  // Level only moves once the last two stages agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
  end

  // Pins idle high through the pull-ups
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= {4 * W{`QBG_SYNC_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_level = st_reg.lvl;

  a_sync_agree: assert property (@(posedge clk) disable iff (!resetn)
    (pin_level != $past(pin_level)) |-> (pin_level == $past(st_reg.s3)))
    else $error("synchronised level moved without agreement");
endmodule

// ==== src/qbg_pin_cell.sv ====
`timescale 1ns/1ps
`include "qbg_params.svh"
module qbg_pin_cell (
  input wire logic clk,
  input wire logic resetn,
  input qbg_pkg::qbg_mode_t mode,
  input wire logic latch_bit,
  input wire logic alt_out,
  input wire logic pin_level,
  output logic drv_low,
  output logic drv_high,
  output logic pu_strong,
  output logic pu_weak,
  output logic analog_en
);
  import qbg_pkg::*;
  typedef struct packed {
    logic prev;
  } qbg_cell_t;
  qbg_cell_t st_reg;
  qbg_cell_t st_next;
  logic data;
  logic quasi;

  always_comb begin
    st_next = st_reg;
    case (mode)
      QBG_GPIO: data = latch_bit;
      QBG_ANALOG, QBG_INPUT_ONLY: data = 1'b1;
      default: data = alt_out;
    endcase
    quasi = (mode == QBG_GPIO) || (mode == QBG_QUASI_ALT);
    // Delayed copy of the drive data gives the one-clock edge pulse
    st_next.prev = data;
    drv_low = !data && (mode != QBG_ANALOG);
    if (mode == QBG_PUSH_PULL) begin
      drv_high = data;
    end else begin
      drv_high = quasi && data && !st_reg.prev;
    end
    pu_weak = data && (mode != QBG_ANALOG) && (mode != QBG_PUSH_PULL);
    // Pulled low from outside drops the strong pull-up
    pu_strong = pu_weak && pin_level && (mode != QBG_OPEN_DRAIN);
    analog_en = (mode == QBG_ANALOG);
  end

  // Resets high with the latch, so release makes no pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= `QBG_SYNC_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  a_pulse_width: assert property (@(posedge clk) disable iff (!resetn)
    (mode == QBG_GPIO && $past(mode) == QBG_GPIO && $rose(latch_bit))
    |-> drv_high ##1 (!drv_high || mode == QBG_PUSH_PULL))
    else $error("high-side pulse not exactly one clock");
  a_no_rewrite_pulse: assert property (@(posedge clk) disable iff (!resetn)
    (mode == QBG_GPIO && $past(mode) == QBG_GPIO && latch_bit && $past(latch_bit))
    |-> !drv_high)
    else $error("high-side pulse on rewrite of one");
  a_low_drive: assert property (@(posedge clk) disable iff (!resetn)
    (mode == QBG_GPIO && !latch_bit) |-> (drv_low && !drv_high && !pu_weak && !pu_strong))
    else $error("latch zero not driving low");
  a_strong_drop: assert property (@(posedge clk) disable iff (!resetn)
    (!pin_level) |-> !pu_strong)
    else $error("strong pull-up on while pin low");
  c_pulse: cover property (@(posedge clk) disable iff (!resetn)
    (mode == QBG_GPIO && drv_high));
endmodule

// ==== src/qbg_ports.sv ====
`timescale 1ns/1ps
`include "qbg_params.svh"
module qbg_ports #(
  parameter int NP = `QBG_NUM_PORTS,
  parameter int PW = `QBG_PORT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_wr,
  input wire logic sfr_bit_wval,
  input wire logic sfr_bit_rd,
  output logic sfr_hit,
  output logic sfr_bit_hit,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic sfr_bit_rdata,
  output logic sfr_bit_rvalid,
  output logic [PW-1:0] port_one_latch,
  output logic [PW-1:0] port_two_latch,
  output logic [PW-1:0] port_three_latch,
  input qbg_pkg::qbg_mode_t [NP*PW-1:0] pin_mode,
  input wire logic [NP*PW-1:0] alt_data_out,
  output logic [NP*PW-1:0] pin_level,
  input wire logic [NP*PW-1:0] pin_in,
  output logic [NP*PW-1:0] pin_out,
  output logic [NP*PW-1:0] pin_oe,
  output logic [NP*PW-1:0] pin_pu_strong,
  output logic [NP*PW-1:0] pin_pu_weak,
  output logic [NP*PW-1:0] pin_analog_en,
  input wire logic [3:0] core_addr_hi,
  input wire logic [7:0] core_ad_out,
  input wire logic core_ad_oe,
  input wire logic core_rd_n,
  input wire logic core_wr_n,
  input wire logic core_psen_n,
  input wire logic core_ale,
  output logic [7:0] core_ad_in,
  output logic [3:0] upper_addr_out,
  output logic [7:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe,
  input wire logic [7:0] muxed_addr_data_in,
  output logic bus_rd_n,
  output logic bus_wr_n,
  output logic bus_psen_n,
  output logic bus_ale
);
  import qbg_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [NP-1:0][PW-1:0] latch;
    logic [7:0] rdata;
    logic rvalid;
    logic bit_rdata;
    logic bit_rvalid;
    logic [3:0] addr_hi;
    logic [7:0] ad_out;
    logic ad_oe;
    logic rd_n;
    logic wr_n;
    logic psen_n;
    logic ale;
  } qbg_state_t;

  localparam logic [NP-1:0][7:0] PORT_ADDR = {
    `QBG_ADDR_PORT_THREE, `QBG_ADDR_PORT_TWO, `QBG_ADDR_PORT_ONE
  };

  qbg_state_t st_reg;
  qbg_state_t st_next;
  logic [NP-1:0] wsel;
  logic [NP-1:0] bsel;
  logic [`QBG_BIT_IDX_W-1:0] bidx;

  // One-hot port select; bit addresses share the byte decode
  function automatic logic [NP-1:0] port_sel(input logic [7:0] a);
    logic [NP-1:0] s;
    s = '0;
    for (int i = 0; i < NP; i++) begin
      s[i] = (a == PORT_ADDR[i]);
    end
    return s;
  endfunction

  // ************************************************************
  // Register access
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    wsel = port_sel(sfr_addr);
    bsel = port_sel({sfr_bit_addr[7:3], `QBG_BIT_BASE_LOW});
    bidx = sfr_bit_addr[`QBG_BIT_IDX_W-1:0];
    st_next.rvalid = 1'b0;
    st_next.bit_rvalid = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (sfr_wr && wsel[i]) begin
        st_next.latch[i] = sfr_wdata;
      end
      // Bit op lands after a same-cycle byte write
      if (sfr_bit_wr && bsel[i]) begin
        st_next.latch[i][bidx] = sfr_bit_wval;
      end
    end
    if (sfr_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = `QBG_UNMAPPED_RD;
      for (int i = 0; i < NP; i++) begin
        if (wsel[i]) begin
          if (sfr_rmw) begin
            st_next.rdata = st_reg.latch[i];
          end else begin
            st_next.rdata = pin_level[i*PW +: PW];
          end
        end
      end
    end
    if (sfr_bit_rd) begin
      st_next.bit_rvalid = 1'b1;
      st_next.bit_rdata = 1'b0;
      for (int i = 0; i < NP; i++) begin
        if (bsel[i]) begin
          if (sfr_rmw) begin
            st_next.bit_rdata = st_reg.latch[i][bidx];
          end else begin
            st_next.bit_rdata = pin_level[i*PW + int'(bidx)];
          end
        end
      end
    end
    // Bus port outputs are retimed by one clock; the core must allow for it
    st_next.addr_hi = core_addr_hi;
    st_next.ad_out = core_ad_out;
    st_next.ad_oe = core_ad_oe;
    st_next.rd_n = core_rd_n;
    st_next.wr_n = core_wr_n;
    st_next.psen_n = core_psen_n;
    st_next.ale = core_ale;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg.latch <= {NP{`QBG_LATCH_RESET}};
      st_reg.rdata <= `QBG_UNMAPPED_RD;
      st_reg.rvalid <= 1'b0;
      st_reg.bit_rdata <= 1'b0;
      st_reg.bit_rvalid <= 1'b0;
      st_reg.addr_hi <= `QBG_BUS_ADDR_IDLE;
      st_reg.ad_out <= `QBG_BUS_AD_IDLE;
      st_reg.ad_oe <= 1'b0;
      st_reg.rd_n <= 1'b1;
      st_reg.wr_n <= 1'b1;
      st_reg.psen_n <= 1'b1;
      st_reg.ale <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sfr_hit = |port_sel(sfr_addr);
  assign sfr_bit_hit = |port_sel({sfr_bit_addr[7:3], `QBG_BIT_BASE_LOW});
  assign sfr_rdata = st_reg.rdata;
  assign sfr_rvalid = st_reg.rvalid;
  assign sfr_bit_rdata = st_reg.bit_rdata;
  assign sfr_bit_rvalid = st_reg.bit_rvalid;
  assign port_one_latch = st_reg.latch[0];
  assign port_two_latch = st_reg.latch[1];
  assign port_three_latch = st_reg.latch[2];

  // ************************************************************
  // Dedicated bus port
  // ************************************************************
  // Not routed through any port latch or pin cell
  assign upper_addr_out = st_reg.addr_hi;
  assign muxed_addr_data_out = st_reg.ad_out;
  assign muxed_addr_data_oe = st_reg.ad_oe;
  assign core_ad_in = muxed_addr_data_in;
  assign bus_rd_n = st_reg.rd_n;
  assign bus_wr_n = st_reg.wr_n;
  assign bus_psen_n = st_reg.psen_n;
  assign bus_ale = st_reg.ale;

  // ************************************************************
  // Pins
  // ************************************************************
  qbg_pin_sync #(
    .W(NP * PW)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_raw(pin_in),
    .pin_level(pin_level)
  );

  // One cell per pin, each with its own mode select
  for (genvar g = 0; g < NP * PW; g++) begin : g_cell
    logic drv_low;
    logic drv_high;
    qbg_pin_cell u_cell (
      .clk(clk),
      .resetn(resetn),
      .mode(pin_mode[g]),
      .latch_bit(st_reg.latch[g / PW][g % PW]),
      .alt_out(alt_data_out[g]),
      .pin_level(pin_level[g]),
      .drv_low(drv_low),
      .drv_high(drv_high),
      .pu_strong(pin_pu_strong[g]),
      .pu_weak(pin_pu_weak[g]),
      .analog_en(pin_analog_en[g])
    );
    assign pin_out[g] = drv_high;
    assign pin_oe[g] = drv_low || drv_high;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_byte_write: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && sfr_addr == `QBG_ADDR_PORT_TWO && !sfr_bit_wr)
    |=> (port_two_latch == $past(sfr_wdata)))
    else $error("second port latch missed a write");
  a_no_stray_write: assert property (@(posedge clk) disable iff (!resetn)
    (!(sfr_wr && sfr_addr == `QBG_ADDR_PORT_ONE) && !sfr_bit_wr)
    |=> $stable(port_one_latch))
    else $error("first port latch changed without a write");
  a_bit_write: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_bit_wr && sfr_bit_addr[7:3] == `QBG_ADDR_PORT_THREE >> 3 && !sfr_wr)
    |=> (port_three_latch[$past(bidx)] == $past(sfr_bit_wval))
        && (((port_three_latch ^ $past(port_three_latch)) & ~(8'h01 << $past(bidx))) == '0))
    else $error("bit write wrong or touched other bits");
  a_rmw_read: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && sfr_rmw && sfr_addr == `QBG_ADDR_PORT_THREE)
    |=> sfr_rvalid && (sfr_rdata == $past(port_three_latch)))
    else $error("read-modify-write read did not return latch");
  a_pin_read: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && !sfr_rmw && sfr_addr == `QBG_ADDR_PORT_ONE)
    |=> sfr_rvalid && (sfr_rdata == $past(pin_level[PW-1:0])))
    else $error("plain read did not return pin level");
  a_unmapped_read: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && !sfr_hit) |=> (sfr_rdata == `QBG_UNMAPPED_RD))
    else $error("unmapped read not zero");
  a_bus_retime: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (upper_addr_out == $past(core_addr_hi)) && (bus_ale == $past(core_ale)))
    else $error("bus port not following core");
  a_input_ready: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> (port_one_latch & port_two_latch & port_three_latch)
      == `QBG_LATCH_RESET)
    else $error("latches not all ones after reset");

  // Byte writes to the other two ports, and writes that must be ignored
  a_first_write: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && sfr_addr == `QBG_ADDR_PORT_ONE && !sfr_bit_wr)
    |=> (port_one_latch == $past(sfr_wdata)))
    else $error("first port latch missed a write");
  a_third_write: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && sfr_addr == `QBG_ADDR_PORT_THREE && !sfr_bit_wr)
    |=> (port_three_latch == $past(sfr_wdata)))
    else $error("third port latch missed a write");
  a_unmapped_write: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && !sfr_hit && !sfr_bit_wr)
    |=> $stable({port_three_latch, port_two_latch, port_one_latch}))
    else $error("write to a foreign address changed a latch");

  // Read answers: one valid clock, data held until the next read; bus data and strobes follow the core
  a_read_valid: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (sfr_rvalid == $past(sfr_rd)) && (sfr_bit_rvalid == $past(sfr_bit_rd)))
    else $error("read valid not a single clock after the strobe");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_bit_pin_read: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_bit_rd && !sfr_rmw && sfr_bit_addr[7:3] == `QBG_ADDR_PORT_ONE >> 3)
    |=> sfr_bit_rvalid && (sfr_bit_rdata == $past(pin_level[bidx])))
    else $error("plain bit read did not return pin level");
  a_bit_rmw_read: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_bit_rd && sfr_rmw && sfr_bit_addr[7:3] == `QBG_ADDR_PORT_ONE >> 3)
    |=> sfr_bit_rvalid && (sfr_bit_rdata == $past(port_one_latch[bidx])))
    else $error("read-modify-write bit read did not return latch");
  a_bus_strobes: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> (muxed_addr_data_out == $past(core_ad_out))
      && (muxed_addr_data_oe == $past(core_ad_oe)) && (bus_rd_n == $past(core_rd_n))
      && (bus_wr_n == $past(core_wr_n)) && (bus_psen_n == $past(core_psen_n)))
    else $error("bus data or strobes not following core");

  // ************************************************************
  // Cover points
  // ************************************************************
  c_byte_write: cover property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && sfr_hit));
  c_rmw_read: cover property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && sfr_rmw && sfr_hit) ##1 sfr_rvalid);
  c_pin_read: cover property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && !sfr_rmw && sfr_hit) ##1 sfr_rvalid);
  c_bit_clear_set: cover property (@(posedge clk) disable iff (!resetn)
    (sfr_bit_wr && sfr_bit_hit && !sfr_bit_wval) ##1 (sfr_bit_wr && sfr_bit_wval));
endmodule

// ==== sim/qbg_ext_dev.sv ====
`timescale 1ns/1ps
// ********************************
// External devices on the port pins
// ********************************
module qbg_ext_dev (
  input wire logic clk,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_pu,
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  output logic [23:0] pin_in
);
  logic [23:0] float_pat = 24'h5a5a5a;

  // A floating pin must not look like a stable level, so it toggles
  always @(posedge clk) float_pat <= ~float_pat;

  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pin_pu[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_pat[i];
      end
    end
  end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import qbg_pkg::*;
  logic clk, resetn, sfr_wr, sfr_rd, sfr_rmw, sfr_bit_wr, sfr_bit_wval, sfr_bit_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, core_ad_out, core_ad_in;
  logic [7:0] muxed_in, muxed_out;
  logic sfr_hit, sfr_bit_hit, sfr_rvalid, sfr_bit_rdata, sfr_bit_rvalid, core_ad_oe, mux_oe;
  logic [7:0] lat1, lat2, lat3, d;
  qbg_mode_t [23:0] pin_mode;
  logic [23:0] alt_data, pin_level, pin_in, pin_out, pin_oe, pus, puw, pan, ext_en, ext_val;
  logic [3:0] core_addr_hi, upper_addr_out, core_ctl, bus_ctl;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  // ********************************
  // Design, partner and clock
  // ********************************
  qbg_ports dut_u (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_wval(sfr_bit_wval), .sfr_bit_rd(sfr_bit_rd),
    .sfr_hit(sfr_hit), .sfr_bit_hit(sfr_bit_hit), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .sfr_bit_rdata(sfr_bit_rdata), .sfr_bit_rvalid(sfr_bit_rvalid),
    .port_one_latch(lat1), .port_two_latch(lat2), .port_three_latch(lat3),
    .pin_mode(pin_mode), .alt_data_out(alt_data), .pin_level(pin_level), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu_strong(pus), .pin_pu_weak(puw),
    .pin_analog_en(pan), .core_addr_hi(core_addr_hi), .core_ad_out(core_ad_out),
    .core_ad_oe(core_ad_oe), .core_rd_n(core_ctl[3]), .core_wr_n(core_ctl[2]),
    .core_psen_n(core_ctl[1]), .core_ale(core_ctl[0]), .core_ad_in(core_ad_in),
    .upper_addr_out(upper_addr_out), .muxed_addr_data_out(muxed_out),
    .muxed_addr_data_oe(mux_oe), .muxed_addr_data_in(muxed_in), .bus_rd_n(bus_ctl[3]),
    .bus_wr_n(bus_ctl[2]), .bus_psen_n(bus_ctl[1]), .bus_ale(bus_ctl[0]));

  qbg_ext_dev ext_u (.clk(clk), .pin_oe(pin_oe), .pin_out(pin_out), .pin_pu(pus | puw),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Ceiling well above the roughly 80 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ********************************
  // Shared tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic bitm, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    if (bitm) begin
      {sfr_bit_wr, sfr_bit_addr, sfr_bit_wval} = {1'b1, a, v[0]};
    end else begin
      {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, v};
    end
    @(negedge clk);
    {sfr_wr, sfr_bit_wr} = 2'b00;
  endtask

  // Bit reads return {valid, 6 zeros, data}
  task automatic rd(input logic bitm, input logic rmw, input logic [7:0] a);
    @(negedge clk);
    sfr_rmw = rmw;
    if (bitm) begin
      {sfr_bit_rd, sfr_bit_addr} = {1'b1, a};
    end else begin
      {sfr_rd, sfr_addr} = {1'b1, a};
    end
    @(negedge clk);
    {sfr_rd, sfr_bit_rd} = 2'b00;
    d = bitm ? {sfr_bit_rvalid, 6'h00, sfr_bit_rdata} : sfr_rdata;
    chk(bitm ? sfr_bit_rvalid : sfr_rvalid, 1'b1);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    chk({lat3, lat2, lat1}, 24'hffffff);
    chk(pin_oe, 24'h000000);
    chk(puw, 24'hffffff);
    $display("test reset done");
  endtask

  task automatic t_drive();
    wr(1'b0, 8'hb0, 8'h00);
    chk({pin_oe[15:8], pin_out[15:8], puw[15:8], pus[15:8]}, 32'hff000000);
    wr(1'b0, 8'hb0, 8'h0f);
    chk({pin_oe[15:8], pin_out[15:8]}, 16'hff0f);
    @(negedge clk);
    chk({pin_oe[15:8], puw[15:8]}, 16'hf00f);
    wr(1'b0, 8'hb0, 8'hff);
    chk({pin_oe[15:8], pin_out[15:8]}, 16'hf0f0);
    wr(1'b1, 8'hc5, 8'h00);
    chk({lat3, lat2, lat1}, 24'hdfffff);
    chk({sfr_hit, sfr_bit_hit}, 2'b11);
    rd(1'b0, 1'b1, 8'hc0);
    chk(d, 8'hdf);
    wr(1'b0, 8'ha0, 8'h00);
    chk({sfr_hit, sfr_bit_hit}, 2'b01);
    rd(1'b0, 1'b0, 8'ha0);
    chk({d, lat3, lat2, lat1}, 32'h00dfffff);
    $display("test drive done");
  endtask

  task automatic t_read();
    ext_en[2] = 1'b1;
    ext_val[2] = 1'b0;
    repeat (6) @(negedge clk);
    chk({pus[2], puw[2]}, 2'b01);
    chk(pin_level[7:0], 8'hfb);
    rd(1'b0, 1'b0, 8'h90);
    chk(d, 8'hfb);
    wr(1'b1, 8'h95, 8'h00);
    rd(1'b0, 1'b1, 8'h90);
    chk(d, 8'hdf);
    repeat (6) @(negedge clk);
    rd(1'b0, 1'b0, 8'h90);
    chk(d, 8'hdb);
    rd(1'b1, 1'b0, 8'h92);
    chk(d, 8'h80);
    rd(1'b1, 1'b1, 8'h92);
    chk(d, 8'h81);
    $display("test read done");
  endtask

  // Expected {oe, analog, weak pull-up} of pin 17 per mode with alternate data 0
  task automatic t_modes();
    qbg_mode_t m [6] = '{QBG_GPIO, QBG_QUASI_ALT, QBG_OPEN_DRAIN, QBG_ANALOG,
      QBG_PUSH_PULL, QBG_INPUT_ONLY};
    logic [2:0] e [6] = '{3'h1, 3'h4, 3'h4, 3'h2, 3'h4, 3'h1};
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      pin_mode[17] = m[i];
      repeat (2) @(negedge clk);
      chk({pin_oe[17], pan[17], puw[17]}, e[i]);
      chk({pin_oe[16], pan[16], puw[16]}, 3'h1);
    end
    pin_mode[17] = QBG_PUSH_PULL;
    alt_data[17] = 1'b1;
    repeat (3) @(negedge clk);
    chk({pin_oe[17], pin_out[17]}, 2'b11);
    $display("test modes done");
  endtask

  task automatic t_bus();
    @(negedge clk);
    {core_addr_hi, core_ad_out, core_ad_oe, core_ctl, muxed_in} = {4'ha, 8'h5c, 1'b1, 4'h7, 8'h3e};
    #1;
    chk(core_ad_in, 8'h3e);
    @(negedge clk);
    chk({upper_addr_out, muxed_out, mux_oe, bus_ctl}, {4'ha, 8'h5c, 1'b1, 4'h7});
    $display("test bus done");
  endtask

  // A reset in mid-run must undo latch writes and drop every drive
  task automatic t_rereset();
    wr(1'b0, 8'h90, 8'h3c);
    wr(1'b0, 8'hc0, 8'h00);
    chk({lat3, lat1}, 16'h003c);
    @(negedge clk);
    resetn = 1'b0;
    alt_data = 24'h000000;
    for (int i = 0; i < 24; i++) pin_mode[i] = QBG_GPIO;
    repeat (2) @(negedge clk);
    chk({lat3, lat2, lat1}, 24'hffffff);
    chk({upper_addr_out, bus_ctl}, 8'hfe);
    resetn = 1'b1;
    @(negedge clk);
    t_reset();
    $display("test mid-run reset done");
  endtask

  initial begin
    {resetn, sfr_wr, sfr_rd, sfr_rmw, sfr_bit_wr, sfr_bit_wval, sfr_bit_rd} = 7'h00;
    {sfr_addr, sfr_wdata, sfr_bit_addr, core_ad_out, muxed_in} = 40'h0;
    {core_addr_hi, core_ad_oe, core_ctl} = {4'hf, 1'b0, 4'he};
    {alt_data, ext_en, ext_val} = 72'h0;
    for (int i = 0; i < 24; i++) pin_mode[i] = QBG_GPIO;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    t_drive();
    t_read();
    t_modes();
    t_bus();
    t_rereset();
    finish_test();
  end
endmodule
